// *** include/dl_decoder_map.vh ***
// Purpose: Constants for the display list command decoder.
// Assumes: 32-bit list words, Wishbone register offsets in bytes.
// Notes: Type and command codes are the 8-bit header fields.
`ifndef DL_DECODER_MAP_VH
`define DL_DECODER_MAP_VH
`define T_PIXEL 8'h00
`define T_PIXELZ 8'h01
`define T_LINE 8'h02
`define T_LINE_XY 8'h03
`define T_LINE_XYP 8'h04
`define T_TRAP 8'h05
`define T_TRI_XY 8'h06
`define T_TRI_XYP 8'h07
`define T_RECT 8'h09
`define T_BITMAP 8'h0b
`define T_COPY 8'h0d
`define T_COPY_ALT 8'h0f
`define T_TEX 8'h11
`define T_TEX_LOCAL 8'h13
`define T_COPY_ALPHA 8'h1f
`define T_SETV 8'h70
`define T_SETVP 8'h71
`define T_DRAW 8'hf0
`define T_SETREG 8'hf1
`define T_SYNC 8'hfc
`define T_INTR 8'hfd
`define T_NOP 8'hff
`define C_FILL 8'h41
`define C_IMAGE 8'h42
`define C_CHAR 8'h43
`define C_TEX 8'h48
`define C_TILE 8'h49
`define C_TRAP_R 8'h60
`define C_TRAP_L 8'h61
`define C_FAN 8'h62
`define C_FLAGFAN 8'h63
`define C_FLUSH 8'hc1
`define C_FLUSH_Z 8'hc2
`define C_BOUNDS 8'he0
`define C_FILLSHAPE 8'he1
`define C_FLAGCLR 8'he2
`define C_NORMAL 8'hff
`define PCOUNT_PIXEL 4'h2
`define PCOUNT_PIXELZ 4'h3
`define PCOUNT_LINE 4'h5
`define PCOUNT_XY 4'h2
`define PCOUNT_XYP 4'h1
`define A_DL_DATA 8'h00
`define A_STATUS 8'h04
`define A_DEPTH_MODE 8'h08
`define A_LINE_ATTR 8'h0c
`define A_DASH 8'h10
`define A_TRI_ATTR 8'h14
`define A_TEX_ATTR 8'h18
`define A_BLT_ATTR 8'h1c
`define A_TRANS_COLOR 8'h20
`define A_CHAR_ATTR 8'h24
`define A_FG_COLOR 8'h28
`define A_BG_COLOR 8'h2c
`define A_PARAM_BASE 8'h80
`define DEPTH_NEVER 3'h0
`define DEPTH_ALWAYS 3'h1
`define DEPTH_LESS 3'h2
`define DEPTH_LESS_OR_SAME 3'h3
`define DEPTH_EQUAL 3'h4
`define DEPTH_GREATER_OR_SAME 3'h5
`define DEPTH_GREATER 3'h6
`define DEPTH_DIFFERS 3'h7
`endif

// *** logic/display_list_command_decoder.v ***
// Purpose: Fetches, decodes and dispatches display list commands.
// Assumes: One clock; the list FIFO and drawing engine are outside.
// Notes: Drawing starts as a one-cycle pulse with a decoded operation code.
`timescale 1ns/1ps
`include "dl_decoder_map.vh"
module display_list_command_decoder #(
   parameter PARAM_WORDS = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [31:0] fifo_data_i,
   input wire fifo_valid_i,
   output reg fifo_pop_o,
   input wire vsync_i,
   input wire engine_busy_i,
   output reg draw_start_o,
   output reg [7:0] draw_type_o,
   output reg [7:0] draw_cmd_o,
   output reg [1:0] draw_vertex_o,
   output reg line_major_y_o,
   output reg line_no_end_o,
   output reg line_dash_reset_o,
   output reg line_antialias_o,
   output reg tri_attr_used_o,
   output reg tex_from_local_o,
   output reg [1:0] copy_corner_o,
   output reg host_irq_o,
   output reg cmd_error_o,
   output reg [5:0] line_width_o,
   output reg [31:0] dash_pattern_o,
   output reg [2:0] depth_mode_o,
   output reg [2:0] tri_attr_o,
   output reg [7:0] blend_coef_o,
   output reg [4:0] tex_attr_o,
   output reg [5:0] blt_attr_o,
   output reg [15:0] trans_color_o,
   output reg [3:0] char_attr_o,
   output reg [15:0] fg_color_o,
   output reg [15:0] bg_color_o,
   input wire [15:0] new_depth_i,
   input wire [15:0] stored_depth_i,
   output reg depth_pass_o
);
   localparam S_FETCH = 4'b0001;
   localparam S_PARAM = 4'b0010;
   localparam S_WAIT = 4'b0100;
   localparam S_SYNC = 4'b1000;
   reg [3:0] state;
   reg [7:0] hdr_type;
   reg [7:0] hdr_cmd;
   reg [15:0] hdr_low;
   reg [7:0] words_left;
   reg [7:0] reg_addr;
   reg setreg_mode;
   reg [31:0] params [0:PARAM_WORDS-1];
   reg [3:0] pidx;
   reg [31:0] sw_word;
   reg sw_word_valid;
   reg vsync_prev;
   reg [5:0] lw_raw;
   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wb_wr = wb_req && wb_we_i;
   wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   // Software words are merged into the list stream; the FIFO port wins when both present.
   wire word_valid = fifo_valid_i || sw_word_valid;
   wire [31:0] word = fifo_valid_i ? fifo_data_i : sw_word;
   // A popped word stands one more cycle and a software write owns its cycle.
   // Neither of those cycles takes a list word.
   wire take_word = word_valid && !fifo_pop_o && !wb_wr &&
                    (state == S_FETCH || state == S_PARAM);
   wire vsync_rise = vsync_i && !vsync_prev;
   reg [3:0] pcount;
   reg known;
   reg imm_start;
   // Parameter word counts per type; count-field formats use the low byte, SETREG the command byte.
   always @* begin
      pcount = 4'h0;
      known = 1'b1;
      imm_start = 1'b0;
      case (word[31:24])
         `T_PIXEL: pcount = `PCOUNT_PIXEL;
         `T_PIXELZ: pcount = `PCOUNT_PIXELZ;
         `T_LINE: pcount = `PCOUNT_LINE;
         `T_LINE_XY, `T_SETV: pcount = `PCOUNT_XY;
         `T_LINE_XYP, `T_SETVP: pcount = `PCOUNT_XYP;
         `T_TRAP, `T_TRI_XY, `T_TRI_XYP, `T_DRAW: imm_start = 1'b1;
         `T_RECT, `T_BITMAP, `T_COPY, `T_COPY_ALT, `T_TEX, `T_TEX_LOCAL,
         `T_COPY_ALPHA, `T_SETREG, `T_SYNC, `T_INTR, `T_NOP: pcount = 4'h0;
         default: known = 1'b0;
      endcase
   end
   wire [7:0] cnt_field = (word[31:24] == `T_SETREG) ? word[23:16] : word[7:0];
   // Unknown codes inside the counted range stay no-ops.
   wire count_type = known && (word[31:24] >= `T_RECT) && (word[31:24] <= `T_COPY_ALPHA);
   wire [7:0] hdr_words = (word[31:24] == `T_SETREG || count_type) ? cnt_field : {4'h0, pcount};
   // A prohibited vertex code is flagged for line-XY and set-vertex types only; the command still runs.
   wire vtx_bad = (word[1:0] == 2'b11) ||
                  ((word[31:24] == `T_LINE_XY || word[31:24] == `T_LINE_XYP) &&
                   word[1:0] == 2'b10);
   always @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_FETCH;
         hdr_type <= `T_NOP;
         hdr_cmd <= 8'h00;
         hdr_low <= 16'h0000;
         words_left <= 8'h00;
         reg_addr <= 8'h00;
         setreg_mode <= 1'b0;
         pidx <= 4'h0;
         fifo_pop_o <= 1'b0;
         draw_start_o <= 1'b0;
         draw_type_o <= 8'h00;
         draw_cmd_o <= 8'h00;
         draw_vertex_o <= 2'b00;
         line_major_y_o <= 1'b0;
         line_no_end_o <= 1'b0;
         line_dash_reset_o <= 1'b0;
         line_antialias_o <= 1'b0;
         tri_attr_used_o <= 1'b0;
         tex_from_local_o <= 1'b0;
         copy_corner_o <= 2'b00;
         host_irq_o <= 1'b0;
         cmd_error_o <= 1'b0;
         lw_raw <= 6'h01;
         dash_pattern_o <= 32'hffffffff;
         depth_mode_o <= `DEPTH_ALWAYS;
         tri_attr_o <= 3'h0;
         blend_coef_o <= 8'hff;
         tex_attr_o <= 5'h00;
         blt_attr_o <= 6'h03;
         trans_color_o <= 16'h0000;
         char_attr_o <= 4'h0;
         fg_color_o <= 16'hffff;
         bg_color_o <= 16'h0000;
         sw_word <= 32'h00000000;
         sw_word_valid <= 1'b0;
         vsync_prev <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         vsync_prev <= vsync_i;
         draw_start_o <= 1'b0;
         fifo_pop_o <= take_word && fifo_valid_i;
         if (take_word && !fifo_valid_i)
            sw_word_valid <= 1'b0;
         case (state)
            S_FETCH: begin
               if (take_word) begin
                  hdr_type <= word[31:24];
                  hdr_cmd <= word[23:16];
                  hdr_low <= word[15:0];
                  words_left <= hdr_words;
                  reg_addr <= word[7:0];
                  setreg_mode <= (word[31:24] == `T_SETREG);
                  pidx <= 4'h0;
                  if (vtx_bad && (word[31:24] == `T_LINE_XY || word[31:24] == `T_LINE_XYP ||
                                  word[31:24] == `T_SETV || word[31:24] == `T_SETVP))
                     cmd_error_o <= 1'b1;
                  if (!known)
                     cmd_error_o <= 1'b1;
                  if (word[31:24] == `T_INTR)
                     host_irq_o <= 1'b1;
                  // Reserved flag bits are ignored.
                  if (word[31:24] == `T_SYNC && word[0])
                     state <= S_SYNC;
                  else if (hdr_words != 8'h00)
                     state <= S_PARAM;
                  else if (imm_start || count_type) begin
                     draw_start_o <= 1'b1;
                     state <= S_WAIT;
                  end
               end
            end
            S_PARAM: begin
               if (take_word) begin
                  // Register writes step by four bytes; a long payload piles
                  // into the last parameter slot instead of wrapping.
                  if (setreg_mode) begin
                     reg_addr <= reg_addr + 8'h04;
                  end else if (pidx != 4'hf) begin
                     pidx <= pidx + 4'h1;
                  end
                  words_left <= words_left - 8'h01;
                  if (words_left == 8'h01) begin
                     // Parameters are all in place before the start pulse leaves.
                     if (!setreg_mode && hdr_type != `T_SETV && hdr_type != `T_SETVP) begin
                        draw_start_o <= 1'b1;
                        state <= S_WAIT;
                     end else begin
                        state <= S_FETCH;
                     end
                  end
               end
            end
            S_WAIT: begin
               // Busy is trusted only from the cycle after the pulse.
               if (!engine_busy_i && !draw_start_o)
                  state <= S_FETCH;
            end
            S_SYNC: begin
               if (vsync_rise)
                  state <= S_FETCH;
            end
            default: state <= S_FETCH;
         endcase
         if ((state == S_FETCH && take_word) && (imm_start || count_type || pcount != 4'h0)) begin
            draw_type_o <= word[31:24];
            draw_cmd_o <= word[23:16];
            draw_vertex_o <= word[1:0];
            case (word[31:24])
               `T_LINE: begin
                  line_major_y_o <= word[16];
                  line_no_end_o <= word[17];
                  line_dash_reset_o <= word[18];
                  line_antialias_o <= word[19];
               end
               `T_LINE_XY, `T_LINE_XYP: begin
                  draw_vertex_o <= {1'b0, word[16]};
                  line_no_end_o <= word[17];
                  line_dash_reset_o <= word[18];
                  line_antialias_o <= word[19];
               end
               default: begin
               end
            endcase
            // XY triangles skip shading and blend attributes.
            tri_attr_used_o <= (word[31:24] == `T_TRAP);
            tex_from_local_o <= (word[31:24] == `T_TEX_LOCAL);
            copy_corner_o <= word[17:16];
         end
         // Software register port and list register writes share one decoder.
         // A registered acknowledge answers every access after one cycle.
         wb_ack_o <= wb_req;
         if (wb_wr && wb_adr_i == `A_DL_DATA) begin
            sw_word <= wb_dat_i;
            sw_word_valid <= 1'b1;
         end
         if (wb_wr && wb_adr_i == `A_STATUS) begin
            if (wb_dat_i[0])
               host_irq_o <= 1'b0;
            if (wb_dat_i[1])
               cmd_error_o <= 1'b0;
         end
         if (state == S_FETCH && take_word && word[31:24] == `T_INTR)
            host_irq_o <= 1'b1;
         if ((wb_wr && wb_adr_i == `A_DEPTH_MODE) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_DEPTH_MODE))
            depth_mode_o <= wb_wr ? wb_dat_i[2:0] : word[2:0];
         if ((wb_wr && wb_adr_i == `A_LINE_ATTR) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_LINE_ATTR))
            lw_raw <= wb_wr ? wb_dat_i[5:0] : word[5:0];
         if ((wb_wr && wb_adr_i == `A_DASH) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_DASH))
            dash_pattern_o <= wb_wr ? ((dash_pattern_o & ~wmask) | (wb_dat_i & wmask)) : word;
         if ((wb_wr && wb_adr_i == `A_TRI_ATTR) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_TRI_ATTR)) begin
            tri_attr_o <= wb_wr ? wb_dat_i[2:0] : word[2:0];
            blend_coef_o <= wb_wr ? wb_dat_i[15:8] : word[15:8];
         end
         if ((wb_wr && wb_adr_i == `A_TEX_ATTR) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_TEX_ATTR))
            tex_attr_o <= wb_wr ? wb_dat_i[4:0] : word[4:0];
         if ((wb_wr && wb_adr_i == `A_BLT_ATTR) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_BLT_ATTR))
            blt_attr_o <= wb_wr ? wb_dat_i[5:0] : word[5:0];
         if ((wb_wr && wb_adr_i == `A_TRANS_COLOR) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_TRANS_COLOR))
            trans_color_o <= wb_wr ? wb_dat_i[15:0] : word[15:0];
         if ((wb_wr && wb_adr_i == `A_CHAR_ATTR) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_CHAR_ATTR))
            char_attr_o <= wb_wr ? wb_dat_i[3:0] : word[3:0];
         if ((wb_wr && wb_adr_i == `A_FG_COLOR) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_FG_COLOR))
            fg_color_o <= wb_wr ? wb_dat_i[15:0] : word[15:0];
         if ((wb_wr && wb_adr_i == `A_BG_COLOR) ||
             (state == S_PARAM && take_word && setreg_mode && reg_addr == `A_BG_COLOR))
            bg_color_o <= wb_wr ? wb_dat_i[15:0] : word[15:0];
         case (wb_adr_i)
            `A_STATUS: wb_dat_o <= {22'h000000, sw_word_valid, engine_busy_i, state,
                                    2'b00, cmd_error_o, host_irq_o};
            `A_DEPTH_MODE: wb_dat_o <= {29'h0, depth_mode_o};
            `A_LINE_ATTR: wb_dat_o <= {26'h0, lw_raw};
            `A_DASH: wb_dat_o <= dash_pattern_o;
            `A_TRI_ATTR: wb_dat_o <= {16'h0, blend_coef_o, 5'h0, tri_attr_o};
            `A_TEX_ATTR: wb_dat_o <= {27'h0, tex_attr_o};
            `A_BLT_ATTR: wb_dat_o <= {26'h0, blt_attr_o};
            `A_TRANS_COLOR: wb_dat_o <= {16'h0, trans_color_o};
            `A_CHAR_ATTR: wb_dat_o <= {28'h0, char_attr_o};
            `A_FG_COLOR: wb_dat_o <= {16'h0, fg_color_o};
            `A_BG_COLOR: wb_dat_o <= {16'h0, bg_color_o};
            default: wb_dat_o <= (wb_adr_i >= `A_PARAM_BASE) ?
                                 params[wb_adr_i[5:2]] : 32'h00000000;
         endcase
      end
   end
   // Parameter words land in the parameter array as they arrive.
   // Reset clears it so an unused slot reads as zero.
   integer pi;
   always @(posedge clk_i) begin
      if (rst_i) begin
         for (pi = 0; pi < PARAM_WORDS; pi = pi + 1)
            params[pi] <= 32'h00000000;
      end else if (state == S_PARAM && take_word && !setreg_mode) begin
         params[pidx] <= word;
      end
   end
   // Width codes 0 and above 32 are held to the legal range.
   always @(posedge clk_i) begin
      if (rst_i)
         line_width_o <= 6'h01;
      else if (lw_raw == 6'h00)
         line_width_o <= 6'h01;
      else if (lw_raw > 6'h20)
         line_width_o <= 6'h20;
      else
         line_width_o <= lw_raw;
   end
   // The result trails its inputs and mode by one cycle.
   always @(posedge clk_i) begin
      if (rst_i)
         depth_pass_o <= 1'b0;
      else
         case (depth_mode_o)
            `DEPTH_NEVER: depth_pass_o <= 1'b0;
            `DEPTH_ALWAYS: depth_pass_o <= 1'b1;
            `DEPTH_LESS: depth_pass_o <= new_depth_i < stored_depth_i;
            `DEPTH_LESS_OR_SAME: depth_pass_o <= new_depth_i <= stored_depth_i;
            `DEPTH_EQUAL: depth_pass_o <= new_depth_i == stored_depth_i;
            `DEPTH_GREATER_OR_SAME: depth_pass_o <= new_depth_i >= stored_depth_i;
            `DEPTH_GREATER: depth_pass_o <= new_depth_i > stored_depth_i;
            default: depth_pass_o <= new_depth_i != stored_depth_i;
         endcase
   end
endmodule // display_list_command_decoder

// *** sim/dl_decoder_checker.sv ***
// Purpose: Port assertions for the display list command decoder.
// Assumes: One clock, synchronous active-high reset.
// Notes: The depth result is rebuilt here from the compare codes, not taken from the design.
`timescale 1ns/1ps
`include "dl_decoder_map.vh"
module dl_decoder_checker (
   input wire clk_i,
   input wire rst_i,
   input wire [7:0] wb_adr_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire fifo_valid_i,
   input wire fifo_pop_o,
   input wire draw_start_o,
   input wire [7:0] draw_type_o,
   input wire [7:0] draw_cmd_o,
   input wire line_major_y_o,
   input wire line_no_end_o,
   input wire line_dash_reset_o,
   input wire line_antialias_o,
   input wire tri_attr_used_o,
   input wire [1:0] copy_corner_o,
   input wire host_irq_o,
   input wire [5:0] line_width_o,
   input wire [2:0] depth_mode_o,
   input wire [15:0] new_depth_i,
   input wire [15:0] stored_depth_i,
   input wire depth_pass_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   function automatic logic dp(input logic [2:0] m, input logic [15:0] n, input logic [15:0] s);
      case (m)
         3'h0: dp = 1'b0;
         3'h1: dp = 1'b1;
         3'h2: dp = n < s;
         3'h3: dp = n <= s;
         3'h4: dp = n == s;
         3'h5: dp = n >= s;
         3'h6: dp = n > s;
         default: dp = n != s;
      endcase
   endfunction
   property p_depth;
      !$past(rst_i) |-> depth_pass_o == dp($past(depth_mode_o), $past(new_depth_i),
         $past(stored_depth_i));
   endproperty
   a_depth: assert property (p_depth) else $error("depth result wrong");
   property p_width;
      line_width_o >= 6'd1 && line_width_o <= 6'd32;
   endproperty
   a_width: assert property (p_width) else $error("line width out of range");
   property p_line_flags;
      draw_start_o && draw_type_o[7:1] == 7'h01 |-> {line_antialias_o, line_dash_reset_o,
         line_no_end_o} == draw_cmd_o[3:1] && (draw_type_o[0] || line_major_y_o == draw_cmd_o[0]);
   endproperty
   a_line_flags: assert property (p_line_flags) else $error("line flags wrong");
   property p_corner;
      draw_start_o && (draw_type_o == `T_COPY || draw_type_o == `T_COPY_ALT)
         |-> copy_corner_o == draw_cmd_o[1:0];
   endproperty
   a_corner: assert property (p_corner) else $error("copy corner wrong");
   property p_tri_used;
      draw_start_o |-> tri_attr_used_o == (draw_type_o == `T_TRAP);
   endproperty
   a_tri_used: assert property (p_tri_used) else $error("triangle attribute use wrong");
   property p_pop;
      fifo_pop_o |-> $past(fifo_valid_i);
   endproperty
   a_pop: assert property (p_pop) else $error("pop without a word");
   property p_irq_hold;
      host_irq_o && !(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `A_STATUS) |=> host_irq_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt request lost");
   property p_start_gap;
      draw_start_o |=> !draw_start_o;
   endproperty
   a_start_gap: assert property (p_start_gap) else $error("starts overlap");
endmodule // dl_decoder_checker

// *** sim/dl_feeder.sv ***
// Purpose: List producer that feeds the decoder FIFO port.
// Assumes: First-word-fall-through; a word leaves on the pop pulse.
// Notes: Idle data is inverted each cycle so a stale word never looks current.
`timescale 1ns/1ps
module dl_feeder (
   input wire clk_i,
   input wire rst_i,
   input wire pop_i,
   output logic [31:0] data_o,
   output logic valid_o
);
   logic [31:0] q[$];
   function automatic void push(input logic [31:0] w);
      q.push_back(w);
   endfunction
   always @(posedge clk_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
         data_o <= 32'h0;
      end else begin
         if (pop_i && q.size() != 0) void'(q.pop_front());
         // A presented word is never withdrawn; gaps fall only between words.
         if (q.size() != 0 && ((valid_o && !pop_i) || $urandom_range(0, 3) != 0)) begin
            valid_o <= 1'b1;
            data_o <= q[0];
         end else begin
            valid_o <= 1'b0;
            data_o <= ~data_o;
         end
      end
   end
endmodule // dl_feeder

// *** sim/test_display_list_command_decoder.sv ***
// Purpose: Self-checking bench for the display list command decoder.
// Assumes: Classic Wishbone master, list fed by the producer model.
// Notes: Expected draw starts queue up as commands are sent.
`timescale 1ns/1ps
`include "dl_decoder_map.vh"
module test_display_list_command_decoder;
   logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
   logic vsync_i = 0, engine_busy_i = 0;
   logic [7:0] wb_adr_i = 0;
   logic [3:0] wb_sel_i = 0;
   logic [31:0] wb_dat_i = 0, rd;
   logic [15:0] new_depth_i = 0, stored_depth_i = 0, e, exp_q[$];
   wire [31:0] wb_dat_o, fifo_data_i, dash_pattern_o;
   wire [7:0] draw_type_o, draw_cmd_o;
   wire [5:0] line_width_o;
   wire [2:0] depth_mode_o;
   wire wb_ack_o, fifo_valid_i, fifo_pop_o, draw_start_o, line_major_y_o, line_no_end_o;
   wire line_dash_reset_o, line_antialias_o, tri_attr_used_o, host_irq_o, cmd_error_o;
   wire depth_pass_o, tex_from_local_o;
   wire [1:0] draw_vertex_o;
   int failures = 0, cmp_count = 0, starts = 0, s;
   logic [7:0] ra[6] = '{`A_DEPTH_MODE, `A_LINE_ATTR, `A_DASH, `A_BLT_ATTR, `A_FG_COLOR, 8'h3c};
   logic [31:0] rv[6] = '{32'h1, 32'h1, 32'hffffffff, 32'h3, 32'hffff, 32'h0};
   logic [31:0] wi[6] = '{0, 1, 17, 32, 33, 63}, wo[6] = '{1, 1, 17, 32, 32, 32};
   logic [7:0] aa[4] = '{`A_TRI_ATTR, `A_TEX_ATTR, `A_BLT_ATTR, `A_CHAR_ATTR};
   logic [31:0] am[4] = '{32'hff07, 32'h1f, 32'h3f, 32'hf};
   // Fields: type, command, low byte, word count, start expected.
   logic [31:0] mt[18] = '{32'h05600001, 32'h05610001, 32'h06620201, 32'h07630101,
      32'h70e00020, 32'hf0e10001, 32'h09e20001, 32'h09410221, 32'h09420331, 32'h0b430221,
      32'h11480221, 32'h13490111, 32'h0d440111, 32'h0d450111, 32'h0f460111, 32'h0f470111,
      32'hf0c10001, 32'hf0c20001};
   display_list_command_decoder dut_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
      .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .fifo_data_i, .fifo_valid_i,
      .fifo_pop_o, .vsync_i, .engine_busy_i, .draw_start_o, .draw_type_o, .draw_cmd_o,
      .draw_vertex_o, .line_major_y_o, .line_no_end_o, .line_dash_reset_o, .line_antialias_o,
      .tri_attr_used_o, .tex_from_local_o, .copy_corner_o(), .host_irq_o, .cmd_error_o,
      .line_width_o, .dash_pattern_o, .depth_mode_o, .tri_attr_o(), .blend_coef_o(),
      .tex_attr_o(), .blt_attr_o(), .trans_color_o(), .char_attr_o(), .fg_color_o(),
      .bg_color_o(), .new_depth_i, .stored_depth_i, .depth_pass_o);
   dl_feeder fu (.clk_i(clk_i), .rst_i(rst_i), .pop_i(fifo_pop_o), .data_o(fifo_data_i),
      .valid_o(fifo_valid_i));
   always #50 clk_i = ~clk_i;
   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task tmo;
      failures++;
      conclude();
   endtask
   task automatic chk(input string n, input logic [31:0] v, input logic [31:0] x);
      cmp_count++;
      if (v !== x) begin
         failures++;
         $display("BAD %s exp %h seen %h", n, x, v);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] sl);
      int n;
      n = 0;
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= sl;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      rd = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
   endtask
   task automatic cmd(input logic [7:0] t, input logic [7:0] c, input logic [15:0] lo,
      input int n, input logic d);
      fu.push({t, c, lo});
      repeat (n) fu.push($urandom);
      if (d) exp_q.push_back({t, c});
   endtask
   task drain;
      int n;
      n = 0;
      while ((exp_q.size() != 0 || fu.q.size() != 0) && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 3000) tmo();
      repeat (8) @(posedge clk_i);
   endtask
   // The engine stays busy a random while after each start.
   always @(posedge clk_i) engine_busy_i <= draw_start_o | (engine_busy_i & ($urandom % 3 != 0));
   always @(posedge clk_i) begin
      if (!rst_i && draw_start_o === 1'b1) begin
         starts++;
         if (exp_q.size() == 0) chk("unexpected_start", 1, 0);
         else begin
            e = exp_q.pop_front();
            chk("type_cmd", {draw_type_o, draw_cmd_o}, e);
            chk("tri_used", tri_attr_used_o, e[15:8] == `T_TRAP);
            if (e[15:9] == 7'h01) chk("line_flags", {line_antialias_o, line_dash_reset_o,
               line_no_end_o}, e[3:1]);
            if (e[15:8] == `T_LINE) chk("line_axis", line_major_y_o, e[0]);
            if (e[15:8] == `T_LINE_XY) chk("start_vertex", draw_vertex_o, e[0]);
            chk("tex_local", tex_from_local_o, e[15:8] == `T_TEX_LOCAL);
         end
      end
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      tmo();
   end
   initial begin
      void'($urandom(2910));
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      for (int i = 0; i < 6; i++) begin
         wb(0, ra[i], 0, 4'hf);
         chk("reset_value", rd, rv[i]);
      end
      for (int i = 0; i < 4; i++) begin
         s = $urandom;
         wb(1, aa[i], s, 4'hf);
         wb(0, aa[i], 0, 4'hf);
         chk("attr_rw", rd, s & am[i]);
      end
      for (int m = 0; m < 8; m++) begin
         wb(1, `A_DEPTH_MODE, m, 4'hf);
         wb(0, `A_DEPTH_MODE, 0, 4'hf);
         chk("depth_mode", rd, m);
         repeat (4) begin
            new_depth_i <= $urandom_range(0, 2);
            stored_depth_i <= $urandom_range(0, 2);
            @(posedge clk_i);
         end
      end
      for (int i = 0; i < 6; i++) begin
         wb(1, `A_LINE_ATTR, wi[i], 4'hf);
         chk("line_width", line_width_o, wo[i]);
      end
      wb(1, `A_DASH, 32'h12345678, 4'hf);
      wb(1, `A_DASH, 32'haaaaaaaa, 4'h4);
      chk("dash", dash_pattern_o, 32'h12aa5678);
      fu.push({`T_SETREG, 8'h02, 8'h00, `A_DEPTH_MODE});
      fu.push(32'h5);
      fu.push(32'h14);
      drain();
      chk("setreg_depth", depth_mode_o, 3'h5);
      chk("setreg_width", line_width_o, 6'd20);
      for (int c = 'h20; c < 'h40; c++) begin
         if (c < 'h30) cmd(`T_LINE, c[7:0], 0, `PCOUNT_LINE, 1);
         else cmd(`T_LINE_XY, c[7:0], $urandom_range(0, 1), `PCOUNT_XY, 1);
      end
      foreach (mt[i]) cmd(mt[i][31:24], mt[i][23:16], mt[i][15:8], mt[i][7:4], mt[i][0]);
      drain();
      chk("legal_vertex", cmd_error_o, 0);
      cmd(8'h55, 0, 0, 0, 0);
      cmd(`T_TRAP, `C_TRAP_R, 0, 0, 1);
      drain();
      chk("unknown_type", cmd_error_o, 1);
      wb(1, `A_STATUS, 32'h2, 4'hf);
      chk("error_clear", cmd_error_o, 0);
      cmd(`T_LINE_XY, 8'h30, 16'h2, `PCOUNT_XY, 1);
      drain();
      chk("bad_vertex", cmd_error_o, 1);
      wb(1, `A_STATUS, 32'h2, 4'hf);
      cmd(`T_INTR, 0, 0, 0, 0);
      drain();
      chk("irq_set", host_irq_o, 1);
      wb(1, `A_STATUS, 32'h1, 4'hf);
      chk("irq_clear", host_irq_o, 0);
      cmd(`T_SYNC, 0, 1, 0, 0);
      cmd(`T_TRAP, `C_TRAP_L, 0, 0, 1);
      s = starts;
      repeat (40) @(posedge clk_i);
      chk("sync_wait", starts, s);
      vsync_i <= 1;
      drain();
      vsync_i <= 0;
      cmd(`T_SYNC, 0, 0, 0, 0);
      cmd(`T_TRAP, `C_TRAP_R, 0, 0, 1);
      cmd(`T_DRAW, `C_FLUSH, 0, 0, 1);
      cmd(`T_DRAW, `C_FLUSH_Z, 0, 0, 1);
      drain();
      chk("sync_no_wait", starts, s + 4);
      conclude();
   end
endmodule // test_display_list_command_decoder
bind display_list_command_decoder dl_decoder_checker chk_u (.clk_i, .rst_i, .wb_adr_i, .wb_we_i,
   .wb_cyc_i, .wb_stb_i, .fifo_valid_i, .fifo_pop_o, .draw_start_o, .draw_type_o, .draw_cmd_o,
   .line_major_y_o, .line_no_end_o, .line_dash_reset_o, .line_antialias_o, .tri_attr_used_o,
   .copy_corner_o, .host_irq_o, .line_width_o, .depth_mode_o, .new_depth_i, .stored_depth_i,
   .depth_pass_o);
